// *** logic/sys_services_defs.svh ***
`ifndef SYS_SERVICES_DEFS_SVH
`define SYS_SERVICES_DEFS_SVH
// Overview of operation
// RULE1: link 0 runs at 10 Mbit/s when its select is low, 20 Mbit/s when high.
// RULE2: second select sets links 1 to 3 jointly, 10 or 20 Mbit/s, apart from link 0.
// RULE3: a 5 MHz reference is taken in and faster internal clocks derived from it.
// RULE4: reset clears both the processor and the rest of the module; module reset here leaves sw_err_q and the fault output uncleared.
// RULE5: the controller holds reset asserted for at least 100 ms.
// RULE6: the controller waits a further 100 ms after release before using any link.
// RULE7: after the post-reset delay, a boot packet is accepted on the first busy link.
// RULE8: halt input together with reset stops the processor for inspection.
// RULE9: while halted for inspection, interrogation is answered on any link.
// RULE10: fault output is pulled low on internal error, otherwise left undriven.
// RULE11: up to 10 fault outputs may be joined; line is low when any drives low.
// RULE12: unconnected link inputs settle to idle so no traffic is seen.
// RULE13: rate selects stay stable except while the module is held in reset.
`define CLK_HZ 20000000
`define REF_HZ 5000000
`define FAST_RATE_BPS 20000000
`define SLOW_RATE_BPS 10000000
`define SLOW_BIT_CYCLES (`CLK_HZ / `SLOW_RATE_BPS)
`define FAST_BIT_CYCLES (`CLK_HZ / `FAST_RATE_BPS)
`define RESET_HOLD_MS 100
`define BOOT_DELAY_MS 100
`define BOOT_DELAY_CYCLES ((`CLK_HZ / 1000) * `BOOT_DELAY_MS)
`define REF_MULT 4
`define MAX_FAULT_WIRED 10
`define LINK_COUNT 4
`define REG_STATUS 8'h00
`define REG_CONTROL 8'h04
`define REG_RATE 8'h08
`define CTRL_ERROR_BIT 0
`define CTRL_HALT_RESUME_BIT 1
`endif

// *** logic/sys_services_pkg.sv ***
package sys_services_pkg;
   typedef enum logic [3:0] {
      ST_RESET = 4'b0001,
      ST_WAIT = 4'b0010,
      ST_READY = 4'b0100,
      ST_HALT = 4'b1000
   } seq_state_e;
   typedef logic [1:0] link_id_t;
endpackage

// *** logic/link_rate_tick.sv ***
`timescale 1ns/1ps
`include "sys_services_defs.svh"
module link_rate_tick (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic fast,
   output logic tick
);
   logic [1:0] cnt_q;
   wire logic [1:0] period_w = fast ? 2'(`FAST_BIT_CYCLES - 1) : 2'(`SLOW_BIT_CYCLES - 1);
   wire logic wrap_w = (cnt_q >= period_w);
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= 2'h0;
         tick <= 1'b0;
      end else begin
         cnt_q <= wrap_w ? 2'h0 : cnt_q + 2'h1;
         tick <= wrap_w;
      end
   end
endmodule

// *** logic/module_system_services.sv ***
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "sys_services_defs.svh"
module module_system_services
   import sys_services_pkg::*;
#(
   parameter int unsigned BOOT_DELAY = `BOOT_DELAY_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic ref_clk_in,
   input wire logic module_reset,
   input wire logic halt_inspect,
   input wire logic port0_rate_select,
   input wire logic port123_rate_select,
   input wire logic [3:0] serial_port_inputs,
   input wire logic cpu_error,
   input wire logic [31:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic fault_flag_n_o,
   output logic fault_flag_n_oe,
   output logic cpu_reset_n,
   output logic cpu_halted,
   output logic boot_ready,
   output logic [3:0] boot_link_onehot,
   output logic [3:0] link_fast,
   output logic [3:0] link_bit_tick,
   output logic ref_clk_fast
);
   // all pin inputs pass two flops; stage one is read only by stage two
   // module reset pin reads as asserted until seen low, so the cpu is never freed early
   logic [9:0] sync1_q, sync2_q;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_q <= 10'h100;
         sync2_q <= 10'h100;
      end else begin
         sync1_q <= {ref_clk_in, module_reset, halt_inspect, port0_rate_select,
                     port123_rate_select, cpu_error, serial_port_inputs};
         sync2_q <= sync1_q;
      end
   end
   wire logic ref_s = sync2_q[9];
   wire logic mrst_s = sync2_q[8];
   wire logic halt_s = sync2_q[7];
   wire logic rate0_s = sync2_q[6];
   wire logic rate123_s = sync2_q[5];
   wire logic err_s = sync2_q[4];
   // inputs held low externally when open, so a floating link reads idle
   wire logic [3:0] link_s = sync2_q[3:0]; // RULE12

   // rates latched only while held in reset so a glitchy select cannot upset a live link
   logic [3:0] fast_q;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         fast_q <= 4'h0;
      end else if (mrst_s) begin
         fast_q <= {{3{rate123_s}}, rate0_s}; // RULE1 RULE2 RULE13
      end
   end
   assign link_fast = fast_q;
   genvar g;
   generate
      for (g = 0; g < `LINK_COUNT; g++) begin : g_tick
         link_rate_tick u_tick (
            .sys_clk(sys_clk),
            .rst_b(rst_b),
            .fast(fast_q[g]),
            .tick(link_bit_tick[g])
         );
      end
   endgenerate

   // fast clock derived from reference: toggle at every rising system edge while ref edges arrive
   logic ref_d_q, fast_clk_q;
   logic [2:0] mult_q;
   wire logic ref_edge_w = ref_s & ~ref_d_q;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ref_d_q <= 1'b0;
         mult_q <= 3'h0;
         fast_clk_q <= 1'b0;
      end else begin
         ref_d_q <= ref_s;
         mult_q <= ref_edge_w ? 3'(`REF_MULT) : (mult_q != 3'h0 ? mult_q - 3'h1 : 3'h0);
         fast_clk_q <= (mult_q != 3'h0) ? ~fast_clk_q : 1'b0; // RULE3
      end
   end
   assign ref_clk_fast = fast_clk_q;

   // reset and boot sequence
   seq_state_e state_q, state_d;
   logic [31:0] wait_q;
   logic halt_req_q;
   logic [3:0] boot_q;
   wire logic wait_done_w = (wait_q >= BOOT_DELAY - 1);
   wire logic any_link_w = |link_s;
   wire logic [3:0] first_w = link_s & ~(link_s - 4'h1);
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_RESET: if (!mrst_s) state_d = halt_req_q ? ST_HALT : ST_WAIT;
         ST_WAIT: if (wait_done_w) state_d = ST_READY;
         ST_READY: state_d = ST_READY;
         ST_HALT: state_d = ST_HALT;
         default: state_d = ST_RESET;
      endcase
      if (mrst_s) state_d = ST_RESET; // RULE4
   end
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= ST_RESET;
         wait_q <= 32'h0;
         halt_req_q <= 1'b0;
         boot_q <= 4'h0;
      end else begin
         state_q <= state_d;
         wait_q <= (state_q == ST_WAIT) ? wait_q + 32'h1 : 32'h0; // RULE6
         if (mrst_s) halt_req_q <= halt_s; // RULE8
         if (state_q != ST_READY) boot_q <= 4'h0;
         else if (boot_q == 4'h0 && any_link_w) boot_q <= first_w; // RULE7
      end
   end
   // outputs registered
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cpu_reset_n <= 1'b0;
         cpu_halted <= 1'b0;
         boot_ready <= 1'b0;
         boot_link_onehot <= 4'h0;
      end else begin
         cpu_reset_n <= (state_d == ST_READY) || (state_d == ST_WAIT) || (state_d == ST_HALT);
         cpu_halted <= (state_d == ST_HALT); // RULE8 RULE9
         boot_ready <= (state_d == ST_READY);
         boot_link_onehot <= boot_q;
      end
   end

   // open-drain fault: enable only to pull low, never drive high
   logic sw_err_q;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         fault_flag_n_oe <= 1'b0;
         fault_flag_n_o <= 1'b0;
      end else begin
         fault_flag_n_oe <= err_s | sw_err_q; // RULE10 RULE11
         fault_flag_n_o <= 1'b0;
      end
   end

   // apb slave, zero wait states
   wire logic acc_w = psel & penable;
   wire logic wr_w = acc_w & pwrite;
   wire logic hit_stat = (paddr[7:0] == `REG_STATUS);
   wire logic hit_ctrl = (paddr[7:0] == `REG_CONTROL);
   wire logic hit_rate = (paddr[7:0] == `REG_RATE);
   wire logic mapped_w = (paddr[31:8] == 24'h0) & (hit_stat | hit_ctrl | hit_rate);
   wire logic [31:0] rd_w = hit_stat ? {20'h0, boot_q, state_q, 1'b0, halt_req_q,
                                        err_s, mrst_s} :
                           hit_ctrl ? {31'h0, sw_err_q} :
                           hit_rate ? {28'h0, fast_q} : 32'h0;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         sw_err_q <= 1'b0;
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         if (wr_w && hit_ctrl && mapped_w) sw_err_q <= pwdata[`CTRL_ERROR_BIT];
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped_w;
         prdata <= (psel & ~penable & ~pwrite & mapped_w) ? rd_w : 32'h0;
      end
   end

   // steps of the multi-cycle checks
   sequence s_cpu_held;
      !cpu_reset_n && !boot_ready && !cpu_halted;
   endsequence
   sequence s_halt_release;
      state_q == ST_RESET && !mrst_s && halt_req_q;
   endsequence
   sequence s_halt_shown;
      ##1 cpu_halted && !boot_ready;
   endsequence
   a_rate_latch: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE1
      mrst_s |=> link_fast[0] == $past(rate0_s)) else $error("rate 0 not latched");
   a_rate_group: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE2
      mrst_s |=> link_fast[3:1] == {3{$past(rate123_s)}}) else $error("rate 1-3 wrong");
   a_rate_hold: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE13
      !mrst_s |=> $stable(link_fast)) else $error("rate moved while live");
   a_reset_cpu: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE4
      mrst_s |=> s_cpu_held) else $error("cpu not in reset");
   a_fault_drive: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE10
      err_s |=> fault_flag_n_oe && !fault_flag_n_o) else $error("fault not pulled");
   a_fault_idle: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE11
      !err_s && !sw_err_q |=> !fault_flag_n_oe) else $error("fault driven idle");
   a_halt_enter: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE8
      s_halt_release |=> s_halt_shown) else $error("halt not entered");
   a_halt_stay: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE8
      cpu_halted && !mrst_s |=> cpu_halted) else $error("halt left early");
   a_halt_live: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE9
      cpu_halted |-> cpu_reset_n && !boot_ready) else $error("halted cpu cannot answer");
   a_boot_wait: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE7
      $rose(boot_ready) |-> $past(wait_q) >= BOOT_DELAY - 1) else $error("boot early");
   a_boot_take: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE7
      state_q == ST_READY && boot_q == 4'h0 && any_link_w
      |=> $onehot(boot_q) && (boot_q & $past(link_s)) == boot_q)
      else $error("boot link not taken");
   a_boot_first: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE7
      boot_q != 4'h0 && state_q == ST_READY |=> $stable(boot_q) || mrst_s)
      else $error("boot link changed");
   a_ref_mult: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE3
      ref_edge_w |=> mult_q == 3'(`REF_MULT)) else $error("ref not seen");
   a_link_idle: assert property (@(posedge sys_clk) disable iff (!rst_b) // RULE12
      state_q == ST_READY && link_s == 4'h0 && boot_q == 4'h0 |=> boot_q == 4'h0)
      else $error("idle link booted");
endmodule

// *** testbench/motherboard_model.sv ***
`timescale 1ns/1ps
module motherboard_model #(
   parameter int HOLD = 12,
   parameter int SETTLE = 40
) (
   input wire logic sys_clk,
   input wire logic fault_flag_n_oe,
   output logic module_reset = 1'b1,
   output logic halt_inspect = 1'b0,
   output logic port0_rate_select = 1'b0,
   output logic port123_rate_select = 1'b0,
   output logic [3:0] serial_port_inputs = 4'h0,
   output logic fault_line
);
   logic [8:0] peer_pull = 9'h000;
   // pull-up on the board; nine peers plus this module share the line
   assign fault_line = ~(|{peer_pull, fault_flag_n_oe});
   task automatic hold_reset(input logic sa, input logic sb, input logic halt);
      module_reset <= 1'b1;
      halt_inspect <= halt;
      port0_rate_select <= sa;
      port123_rate_select <= sb;
      repeat (HOLD) @(posedge sys_clk);
   endtask
   task automatic release_reset();
      module_reset <= 1'b0;
      repeat (SETTLE) @(posedge sys_clk);
   endtask
   task automatic send_burst(input int link);
      serial_port_inputs[link] <= 1'b1;
      repeat (2) @(posedge sys_clk);
      // pull-down returns an unused input to idle
      serial_port_inputs[link] <= 1'b0;
   endtask
   task automatic peer_fault(input logic v);
      peer_pull[0] <= v;
      @(posedge sys_clk);
   endtask
endmodule

// *** testbench/module_system_services_tb_top.sv ***
`timescale 1ns/1ps
module module_system_services_tb_top;
   import sys_services_pkg::*;
   typedef struct {logic sa; logic sb; logic halt; int link; logic [3:0] fst; logic [3:0] bt;} row_s;
   row_s rows[4] = '{'{0, 0, 0, 2, 4'h0, 4'h4}, '{1, 1, 1, 1, 4'hF, 4'h0},
                     '{1, 0, 0, 0, 4'h1, 4'h1}, '{0, 1, 0, 3, 4'hE, 4'h8}};
   logic sys_clk = 0, rst_b = 0, ref_clk_in = 0, cpu_error = 0;
   logic psel = 0, penable = 0, pwrite = 0;
   logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
   logic pready, pslverr, fault_flag_n_o, fault_flag_n_oe, cpu_reset_n, cpu_halted, boot_ready;
   logic module_reset, halt_inspect, port0_rate_select, port123_rate_select, fault_line, err;
   logic ref_clk_fast, fast_prev;
   logic [3:0] serial_port_inputs, boot_link_onehot, link_fast, link_bit_tick;
   int n_fail = 0, tests_run = 0, cycles = 0, c0, c1;
   always #25 sys_clk = ~sys_clk;
   always #100 ref_clk_in = ~ref_clk_in;
   module_system_services #(.BOOT_DELAY(20)) i_module_system_services (.sys_clk(sys_clk),
      .rst_b(rst_b), .ref_clk_in(ref_clk_in), .module_reset(module_reset),
      .halt_inspect(halt_inspect), .port0_rate_select(port0_rate_select),
      .port123_rate_select(port123_rate_select), .serial_port_inputs(serial_port_inputs),
      .cpu_error(cpu_error), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fault_flag_n_o(fault_flag_n_o), .fault_flag_n_oe(fault_flag_n_oe),
      .cpu_reset_n(cpu_reset_n), .cpu_halted(cpu_halted), .boot_ready(boot_ready),
      .boot_link_onehot(boot_link_onehot), .link_fast(link_fast),
      .link_bit_tick(link_bit_tick), .ref_clk_fast(ref_clk_fast));
   motherboard_model i_motherboard_model (.sys_clk(sys_clk), .fault_flag_n_oe(fault_flag_n_oe),
      .module_reset(module_reset), .halt_inspect(halt_inspect),
      .port0_rate_select(port0_rate_select), .port123_rate_select(port123_rate_select),
      .serial_port_inputs(serial_port_inputs), .fault_line(fault_line));
   task automatic stop_test();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // a hung handshake must still reach the verdict
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         n_fail++;
         stop_test();
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) begin
         @(posedge sys_clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   initial begin
      repeat (10) @(posedge sys_clk);
      check("oe in reset", fault_flag_n_oe, 0);
      rst_b <= 1'b1;
      foreach (rows[i]) begin
         i_motherboard_model.hold_reset(rows[i].sa, rows[i].sb, rows[i].halt);
         check("cpu_reset_n", cpu_reset_n, 0);
         i_motherboard_model.release_reset();
         check("cpu_halted", cpu_halted, rows[i].halt);
         check("boot_ready", boot_ready, !rows[i].halt);
         check("link_fast", link_fast, rows[i].fst);
         c0 = 0;
         c1 = 0;
         repeat (8) begin
            @(posedge sys_clk);
            c0 += link_bit_tick[0];
            c1 += link_bit_tick[1] + link_bit_tick[2] + link_bit_tick[3];
         end
         check("ticks link0", c0, rows[i].sa ? 8 : 4);
         check("ticks links1-3", c1, rows[i].sb ? 24 : 12);
         i_motherboard_model.send_burst(rows[i].link);
         i_motherboard_model.send_burst((rows[i].link + 1) % 4);
         repeat (5) @(posedge sys_clk);
         check("boot link", boot_link_onehot, rows[i].bt);
      end
      apb(0, 32'h0000_0008, 0);
      check("rate reg", rd, 32'h0000_000E);
      check("rate no err", err, 0);
      apb(0, 32'h0000_0000, 0);
      check("status", rd[11:4], {4'h8, ST_READY});
      apb(0, 32'h0000_000C, 0);
      check("unmapped err", err, 1);
      cpu_error <= 1'b1;
      repeat (5) @(posedge sys_clk);
      check("oe on error", fault_flag_n_oe, 1);
      check("fault line", {fault_line, fault_flag_n_o}, 2'b00);
      cpu_error <= 1'b0;
      repeat (5) @(posedge sys_clk);
      check("oe idle", fault_flag_n_oe, 0);
      check("line idle", fault_line, 1);
      apb(1, 32'h0000_0004, 32'h0000_0001);
      repeat (4) @(posedge sys_clk);
      check("oe sw fault", fault_flag_n_oe, 1);
      apb(1, 32'h0000_0004, 32'h0000_0000);
      i_motherboard_model.peer_fault(1);
      check("peer low", fault_line, 0);
      i_motherboard_model.peer_fault(0);
      // reference period is four system cycles, so the derived clock never pauses
      c0 = 0;
      fast_prev = ref_clk_fast;
      repeat (40) begin
         @(posedge sys_clk);
         c0 += (ref_clk_fast !== fast_prev);
         fast_prev = ref_clk_fast;
      end
      check("fast clock toggles", c0, 40);
      rst_b <= 1'b0;
      @(posedge sys_clk);
      @(negedge sys_clk);
      check("second reset", {cpu_reset_n, boot_ready}, 2'b00);
      rst_b <= 1'b1;
      repeat (2) @(posedge sys_clk);
      check("cpu held after reset", cpu_reset_n, 0);
      stop_test();
   end
endmodule
